// ### rdm_pkg.sv
package rdm_pkg;
    // received character word layout, as held in the receive buffer
    localparam int          DATA_W      = 8;
    localparam int          DATA_LSB    = 0;
    localparam int          PERR_BIT    = 8;
    localparam int          FERR_BIT    = 9;
    localparam int          BRK_BIT     = 10;
    localparam int          ENTRY_W     = 11;
    // receive buffer depth
    localparam int          BUF_DEPTH   = 2;
    // reset values of control state
    localparam logic        RX_EN_RST   = 1'b0;
    localparam logic        TX_BUSY_RST = 1'b0;
    localparam logic        RTS_N_RST   = 1'b1;
    // parity field code for forced parity 0, expected from the host in multidrop use
    localparam logic [2:0]  FORCE_PAR0  = 3'h7;
endpackage

// ### rdm_stream_if.sv
`timescale 1ns/1ps
interface rdm_stream_if #(
    parameter int WIDTH = rdm_pkg::ENTRY_W
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] entry;

    modport src (output valid, output entry, input ready);
    modport snk (input valid, input entry, output ready);
endinterface

// ### rdm_rx_buf.sv
`timescale 1ns/1ps
module rdm_rx_buf #(
    parameter int WIDTH = rdm_pkg::ENTRY_W,
    parameter int DEPTH = rdm_pkg::BUF_DEPTH
) (
    input wire logic    mclk,   // core clock
    input wire logic    rstn,   // async reset, active low
    rdm_stream_if.snk   fill,   // characters from the receive filter
    rdm_stream_if.src   drain   // head of buffer towards the receive fifo
);
    localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [IW-1:0] LAST_IDX = IW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [IW-1:0]    wr_idx;
    logic [IW-1:0]    rd_idx;
    logic [CW-1:0]    count;
    logic             push;
    logic             pop;

    ////////////////////////////////////////////////////////////////////////////
    // handshakes; an empty buffer shows all-zero status at its head
    assign fill.ready  = (count != FULL_CNT);
    assign drain.valid = (count != '0);
    assign drain.entry = (count != '0) ? mem[rd_idx] : '0;
    assign push        = fill.valid & fill.ready;
    assign pop         = drain.valid & drain.ready;

    // storage; no reset needed, the head is masked while empty
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_idx] <= fill.entry;
        end
    end

    // pointers and occupancy; status of the next word appears after a pop
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wr_idx <= '0;
            rd_idx <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_idx <= (wr_idx == LAST_IDX) ? '0 : wr_idx + 1'b1;
            end
            if (pop) begin
                rd_idx <= (rd_idx == LAST_IDX) ? '0 : rd_idx + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    empty_zero_a: assert property (@(posedge mclk) disable iff (!rstn)
        !drain.valid |-> drain.entry == '0)
        else $error("status bits not zero while buffer empty");
    order_keep_a: assert property (@(posedge mclk) disable iff (!rstn)
        push && count == '0 |=> drain.valid && drain.entry == $past(fill.entry))
        else $error("stored word not shown at head of empty buffer");
endmodule

// ### rdm_rs485_ctrl.sv
`timescale 1ns/1ps
module rdm_rs485_ctrl (
    input  wire logic       mclk,            // core clock, 40 MHz
    input  wire logic       rstn,            // async reset, active low
    input  wire logic       mcr_rts,         // modem control request-to-send bit
    input  wire logic       hw_flow_en,      // hardware flow control enabled
    input  wire logic       hw_flow_rts_n,   // pin level wanted by flow control
    input  wire logic       auto_dir_en,     // auto direction control enable
    input  wire logic       dir_invert,      // invert auto direction polarity
    input  wire logic       tx_write,        // pulse: host wrote transmit fifo
    input  wire logic       tx_fifo_empty,   // transmit fifo holds nothing
    input  wire logic       tx_shift_empty,  // last bit has left the shifter
    input  wire logic       multidrop_en,    // 9-bit multidrop mode enable
    input  wire logic       special_char_en, // special character detect enable
    input  wire logic [7:0] station_addr,    // second stop flow char, own address
    input  wire logic       lsr_irq_en,      // line status interrupt enable
    input  wire logic       rx_en_wr,        // pulse: host writes receiver enable
    input  wire logic       rx_en_wdata,     // value written with rx_en_wr
    input  wire logic       rx_char_valid,   // pulse: a character was received
    input  wire logic [7:0] rx_char,         // received data bits
    input  wire logic       rx_parity_bit,   // received ninth (parity) bit
    input  wire logic       rx_parity_err,   // parity check result, normal mode
    input  wire logic       rx_frame_err,    // framing error of this character
    input  wire logic       rx_break,        // break seen with this character
    output logic            rx_char_ready,   // buffer can take a character
    output logic            rx_overrun,      // pulse: kept character lost, full
    output logic            out_valid,       // receive fifo word available
    input  wire logic       out_ready,       // receive fifo takes the word
    output logic [7:0]      out_data,        // head character
    output logic            out_perr,        // head parity error / address flag
    output logic            out_ferr,        // head framing error
    output logic            out_brk,         // head break flag
    output logic            rx_enabled,      // receiver enable state
    output logic            line_status_irq, // pulse: address line-status event
    output logic            rts_n            // request-to-send pin, active low
);
    rdm_stream_if #(.WIDTH(rdm_pkg::ENTRY_W)) fill_if ();
    rdm_stream_if #(.WIDTH(rdm_pkg::ENTRY_W)) drain_if ();

    logic tx_busy;
    logic next_tx_busy;
    logic next_rts_n;
    logic is_addr;
    logic addr_match;
    logic auto_mode;
    logic keep;
    logic hw_set;
    logic hw_clr;
    logic perr_val;

    ////////////////////////////////////////////////////////////////////////////
    // transmit activity: a write sets, drained fifo and shifter clear; set wins
    always_comb begin
        next_tx_busy = tx_busy;
        if (tx_write) begin
            next_tx_busy = 1'b1;
        end else if (tx_fifo_empty && tx_shift_empty) begin
            next_tx_busy = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tx_busy <= rdm_pkg::TX_BUSY_RST;
        end else begin
            tx_busy <= next_tx_busy;
        end
    end

    // pin source select; flow control is expected off under auto direction
    always_comb begin
        if (auto_dir_en) begin
            next_rts_n = dir_invert ? next_tx_busy : ~next_tx_busy;
        end else if (hw_flow_en) begin
            next_rts_n = hw_flow_rts_n;
        end else begin
            next_rts_n = ~mcr_rts;
        end
    end

    // registered pin so it never glitches while sources switch
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rts_n <= rdm_pkg::RTS_N_RST;
        end else begin
            rts_n <= next_rts_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive filter; host must program forced parity 0 so address reads as perr
    assign is_addr    = multidrop_en & rx_parity_bit;
    assign addr_match = (rx_char == station_addr);
    assign auto_mode  = multidrop_en & special_char_en;

    always_comb begin
        keep     = 1'b1;
        hw_set   = 1'b0;
        hw_clr   = 1'b0;
        perr_val = rx_parity_err;
        if (multidrop_en) begin
            perr_val = rx_parity_bit;
            if (auto_mode) begin
                if (is_addr && addr_match) begin
                    hw_set = rx_char_valid;
                end else if (is_addr) begin
                    hw_clr = rx_char_valid;
                    keep   = 1'b0;
                end else begin
                    keep   = rx_enabled;
                end
            end else begin
                // controller decides per address, so every address is kept
                keep = is_addr | rx_enabled;
            end
        end
    end

    assign fill_if.valid = rx_char_valid & keep;
    assign fill_if.entry = {rx_break, rx_frame_err, perr_val, rx_char};
    assign rx_char_ready = fill_if.ready;

    // receiver enable: address match wins over a host write in the same cycle
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rx_enabled <= rdm_pkg::RX_EN_RST;
        end else if (hw_set) begin
            rx_enabled <= 1'b1;
        end else if (hw_clr) begin
            rx_enabled <= 1'b0;
        end else if (rx_en_wr) begin
            rx_enabled <= rx_en_wdata;
        end
    end

    // line status event for each kept address while lsr_irq_en is set; a lost one also flags overrun
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            line_status_irq <= 1'b0;
            rx_overrun      <= 1'b0;
        end else begin
            line_status_irq <= fill_if.valid & is_addr & lsr_irq_en;
            rx_overrun      <= fill_if.valid & ~fill_if.ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // two-entry buffer absorbs a receive fifo stall for two characters
    rdm_rx_buf #(
        .WIDTH (rdm_pkg::ENTRY_W),
        .DEPTH (rdm_pkg::BUF_DEPTH)
    ) u_buf (
        .mclk  (mclk),
        .rstn  (rstn),
        .fill  (fill_if),
        .drain (drain_if)
    );

    assign out_valid      = drain_if.valid;
    assign drain_if.ready = out_ready;
    assign out_data       = drain_if.entry[rdm_pkg::DATA_LSB +: rdm_pkg::DATA_W];
    assign out_perr       = drain_if.entry[rdm_pkg::PERR_BIT];
    assign out_ferr       = drain_if.entry[rdm_pkg::FERR_BIT];
    assign out_brk        = drain_if.entry[rdm_pkg::BRK_BIT];

    ////////////////////////////////////////////////////////////////////////////
    rts_manual_a: assert property (@(posedge mclk) disable iff (!rstn)
        !auto_dir_en && !hw_flow_en |=> rts_n == !$past(mcr_rts))
        else $error("pin does not follow modem control bit");
    rts_assert_a: assert property (@(posedge mclk) disable iff (!rstn)
        auto_dir_en && !dir_invert && tx_write |=> !rts_n)
        else $error("pin not driven low after transmit write");
    rts_release_a: assert property (@(posedge mclk) disable iff (!rstn)
        auto_dir_en && !dir_invert && !tx_write && tx_fifo_empty && tx_shift_empty
        |=> rts_n)
        else $error("pin not released after last bit");
    rts_invert_a: assert property (@(posedge mclk) disable iff (!rstn)
        auto_dir_en && dir_invert && tx_write ##1 auto_dir_en && dir_invert && !tx_fifo_empty
        |-> rts_n ##1 rts_n)
        else $error("inverted pin not high while sending");
    md_drop_a: assert property (@(posedge mclk) disable iff (!rstn)
        rx_char_valid && multidrop_en && !special_char_en && !rx_parity_bit && !rx_enabled
        |-> !fill_if.valid)
        else $error("data byte kept while receiver disabled");
    md_addr_a: assert property (@(posedge mclk) disable iff (!rstn)
        rx_char_valid && multidrop_en && !special_char_en && rx_parity_bit && lsr_irq_en
        |-> fill_if.valid && fill_if.entry[rdm_pkg::PERR_BIT] ##1 line_status_irq)
        else $error("address byte not flagged and stored");
    auto_match_a: assert property (@(posedge mclk) disable iff (!rstn)
        rx_char_valid && auto_mode && rx_parity_bit && rx_char == station_addr
        |-> fill_if.valid ##1 rx_enabled)
        else $error("matching address not stored or receiver not enabled");
    auto_miss_a: assert property (@(posedge mclk) disable iff (!rstn)
        rx_char_valid && auto_mode && rx_parity_bit && rx_char != station_addr
        |-> !fill_if.valid ##1 !rx_enabled)
        else $error("mismatching address kept or receiver left on");
    auto_data_a: assert property (@(posedge mclk) disable iff (!rstn)
        rx_char_valid && auto_mode && !rx_parity_bit && !rx_enabled |-> !fill_if.valid)
        else $error("data byte kept in auto mode while disabled");
    host_en_a: assert property (@(posedge mclk) disable iff (!rstn)
        rx_en_wr && !rx_char_valid |=> rx_enabled == $past(rx_en_wdata))
        else $error("host receiver enable write lost");
endmodule

// ### rdm_line_model.sv
`timescale 1ns/1ps
// far side model: transmit path timing and the receive fifo reader
module rdm_line_model #(
    parameter int FIFO_CYC  = 8,  // cycles until the transmit fifo runs dry
    parameter int SHIFT_CYC = 10  // cycles the last character spends in the shifter
) (
    input  wire logic mclk,           // core clock
    input  wire logic rstn,           // async reset, active low
    input  wire logic tx_write,       // host wrote a character
    input  wire logic stall,          // reader holds off
    output logic      tx_fifo_empty,  // transmit fifo holds nothing
    output logic      tx_shift_empty, // last bit has left the shifter
    output logic      out_ready       // reader takes the head word
);
    logic [7:0] left;
    ////////////////////////////////////////////////////////////////////////////////
    // a new write restarts the whole transmit time, like a fresh character
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            left <= 8'h00;
        end else if (tx_write) begin
            left <= 8'(FIFO_CYC + SHIFT_CYC);
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
    // fifo drains first, shifter empties last
    assign tx_fifo_empty  = (left <= 8'(SHIFT_CYC));
    assign tx_shift_empty = (left == 8'h00);
    assign out_ready      = !stall;
endmodule

// ### rdm_rs485_ctrl_test.sv
`timescale 1ns/1ps
module rdm_rs485_ctrl_test;
    logic mclk = 1'b0, rstn = 1'b0, mcr_rts = 1'b0, hw_flow_en = 1'b0, hw_flow_rts_n = 1'b1;
    logic auto_dir_en = 1'b0, dir_invert = 1'b0, tx_write = 1'b0, stall = 1'b1;
    logic multidrop_en = 1'b0, special_char_en = 1'b0, lsr_irq_en = 1'b0;
    logic rx_en_wr = 1'b0, rx_en_wdata = 1'b0, rx_char_valid = 1'b0, rx_parity_bit = 1'b0;
    logic rx_parity_err = 1'b0, rx_frame_err = 1'b0, rx_break = 1'b0;
    logic [7:0] station_addr = 8'h5a, rx_char = 8'h00;
    logic tx_fifo_empty, tx_shift_empty, out_ready, rx_char_ready, rx_overrun, out_valid;
    logic out_perr, out_ferr, out_brk, rx_enabled, line_status_irq, rts_n, irq_seen, ovr_seen;
    logic [7:0] out_data;
    int n_fail = 0, comparisons = 0, cycles = 0;
    always #12.5 mclk = !mclk;
    ////////////////////////////////////////////////////////////////////////////////
    rdm_rs485_ctrl uut (.mclk(mclk), .rstn(rstn), .mcr_rts(mcr_rts), .hw_flow_en(hw_flow_en),
        .hw_flow_rts_n(hw_flow_rts_n), .auto_dir_en(auto_dir_en), .dir_invert(dir_invert),
        .tx_write(tx_write), .tx_fifo_empty(tx_fifo_empty), .tx_shift_empty(tx_shift_empty),
        .multidrop_en(multidrop_en), .special_char_en(special_char_en),
        .station_addr(station_addr), .lsr_irq_en(lsr_irq_en), .rx_en_wr(rx_en_wr),
        .rx_en_wdata(rx_en_wdata), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
        .rx_parity_bit(rx_parity_bit), .rx_parity_err(rx_parity_err),
        .rx_frame_err(rx_frame_err), .rx_break(rx_break), .rx_char_ready(rx_char_ready),
        .rx_overrun(rx_overrun), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data), .out_perr(out_perr), .out_ferr(out_ferr), .out_brk(out_brk),
        .rx_enabled(rx_enabled), .line_status_irq(line_status_irq), .rts_n(rts_n));
    rdm_line_model #(.FIFO_CYC(8), .SHIFT_CYC(10)) far (.mclk(mclk), .rstn(rstn),
        .tx_write(tx_write), .stall(stall), .tx_fifo_empty(tx_fifo_empty),
        .tx_shift_empty(tx_shift_empty), .out_ready(out_ready));
    ////////////////////////////////////////////////////////////////////////////////
    // verdict and end of run, reached from the main sequence or the watchdog
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [10:0] seen, input logic [10:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s: saw %h, wanted %h", $time, what, seen, exp);
        end
    endtask
    task automatic chk1(input logic seen, input logic exp, input string what);
        chk({10'h000, seen}, {10'h000, exp}, what);
    endtask
    // one received character, flags as {brk, ferr, perr}; irq and overrun land next cycle
    task automatic send(input logic [7:0] d, input logic p, input logic [2:0] e);
        rx_char = d;
        rx_parity_bit = p;
        {rx_break, rx_frame_err, rx_parity_err} = e;
        rx_char_valid = 1'b1;
        @(negedge mclk);
        rx_char_valid = 1'b0;
        irq_seen = line_status_irq;
        ovr_seen = rx_overrun;
    endtask
    // compare the head word, then let the reader take it for exactly one edge
    task automatic pop(input logic [10:0] exp);
        chk1(out_valid, 1'b1, "head present");
        chk({out_brk, out_ferr, out_perr, out_data}, exp, "head word");
        stall = 1'b0;
        @(negedge mclk);
        stall = 1'b1;
    endtask
    task automatic host_rx_en(input logic v);
        rx_en_wr = 1'b1;
        rx_en_wdata = v;
        @(negedge mclk);
        rx_en_wr = 1'b0;
    endtask
    // watchdog well above the fewer than one hundred cycles the sequence needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(negedge mclk);
        chk1(rts_n, 1'b1, "reset pin");
        chk({out_valid, rx_enabled, line_status_irq, out_data}, 11'h000, "reset rx");
        rstn = 1'b1;
        // pin source selection: modem bit, flow control, then auto direction
        mcr_rts = 1'b1;
        repeat (2) @(negedge mclk);
        chk1(rts_n, 1'b0, "modem bit");
        hw_flow_en = 1'b1;
        repeat (2) @(negedge mclk);
        chk1(rts_n, 1'b1, "flow logic");
        hw_flow_en = 1'b0; // host turns flow control off first
        auto_dir_en = 1'b1;
        for (int inv = 0; inv < 2; inv++) begin
            dir_invert = inv[0];
            repeat (2) @(negedge mclk);
            chk1(rts_n, !inv[0], "auto idle overrides modem bit");
            tx_write = 1'b1;
            @(negedge mclk);
            tx_write = 1'b0;
            chk1(rts_n, inv[0], "driving at write");
            repeat (16) @(negedge mclk);
            chk1(rts_n, inv[0], "still shifting");
            repeat (4) @(negedge mclk);
            chk1(rts_n, !inv[0], "released after last bit");
        end
        $display("test direction done");
        // normal multidrop, receiver disabled at first
        multidrop_en = 1'b1; // host: 9-bit on, detect off, forced parity 0 field
        lsr_irq_en = 1'b1;
        send(8'h44, 1'b0, 3'h0);
        chk1(out_valid, 1'b0, "data dropped while disabled");
        send(8'h21, 1'b1, 3'h0);
        chk1(irq_seen, 1'b1, "address interrupt");
        pop({3'h1, 8'h21});
        host_rx_en(1'b1); // own address, so the controller enables
        chk1(rx_enabled, 1'b1, "host enable");
        send(8'h9c, 1'b0, 3'h0);
        chk1(irq_seen, 1'b0, "no interrupt for data");
        pop({3'h0, 8'h9c});
        lsr_irq_en = 1'b0;
        send(8'h22, 1'b1, 3'h0);
        chk1(irq_seen, 1'b0, "interrupt gated off");
        pop({3'h1, 8'h22});
        host_rx_en(1'b0);
        chk1(rx_enabled, 1'b0, "host disable");
        $display("test normal multidrop done");
        // automatic address match against the stored station address
        special_char_en = 1'b1;
        lsr_irq_en = 1'b1;
        send(8'h5a, 1'b0, 3'h0);
        send(8'h33, 1'b1, 3'h0);
        chk1(out_valid, 1'b0, "data and wrong address discarded");
        send(8'h5a, 1'b1, 3'h0);
        chk1(irq_seen, 1'b1, "match interrupt");
        chk1(rx_enabled, 1'b1, "match enables");
        pop({3'h1, 8'h5a});
        send(8'h11, 1'b0, 3'h0);
        pop({3'h0, 8'h11});
        send(8'h5a, 1'b1, 3'h0);
        pop({3'h1, 8'h5a});
        send(8'h5b, 1'b1, 3'h0);
        chk1(rx_enabled, 1'b0, "mismatch disables");
        chk1(out_valid, 1'b0, "mismatch ignored");
        $display("test auto address done");
        // buffer filled past full with the reader stalled, then drained
        multidrop_en = 1'b0;
        special_char_en = 1'b0;
        send(8'h81, 1'b0, 3'h3);
        send(8'h82, 1'b0, 3'h4);
        chk1(rx_char_ready, 1'b0, "buffer full");
        send(8'h83, 1'b0, 3'h1);
        chk1(ovr_seen, 1'b1, "overrun on full");
        pop({3'h3, 8'h81});
        pop({3'h4, 8'h82});
        chk1(out_valid, 1'b0, "empty head valid");
        chk({out_brk, out_ferr, out_perr, out_data}, 11'h000, "empty head");
        $display("test buffer done");
        complete_run();
    end
endmodule
